//--- core/remote_io_pkg.sv
// Constants shared by the remote I/O and remote register command port
// Contract
// - Remote words are 16 bits in 8-axis mode, low byte only in 16-axis mode.
// - Every remote input bit maps by parameter to any input function; defaults below.
// - In 8-bit mode outputs keep low-byte defaults: selects, start echo, home, ready, warning, alarm.
// - Command code selects parameter read or write, monitor, or maintenance.
// - A command runs only on a 0-to-1 change of the command strobe.
// - Completion acknowledge goes 0-to-1 when the command finishes, else reads 0.
// - Status bit reports 0 for normal completion, 1 for error.
// - The response echoes the executed command code.
// - Write data arrive least significant byte first.
// - Read data return least significant byte first.
// - Positive and negative run move continuously at 1, decelerate to stop at 0.
// - Home, start, sequence, inch and direct-select inputs start their operation at 1.
// - Each direct-select input positions with its own configured data number.
// - Six data-select bits form a binary data number 0 to 63.
// - Release at 1 frees motor and brake; excitation input excites at 1.
// - Stop at 1 stops the motor, 0 has no effect.
// - Alarm clear, absolute error clear and position load act at 1.
// - Tool unlock keeps setting tool limitation at 0, releases it at 1.
// - Sixteen general flags are stored and readable, 1 on and 0 off.
// - A function on several input bits is active when any of them is.
// - Unassigned excitation or tool unlock input counts as permanently 1.
// - A function on both a direct terminal and network bit needs both at 1.
// - Alarm, warning, ready and moving output bits show those drive states.
// - Echo output bits follow their input functions.
package remote_io_pkg;
  localparam int WORD_W = 16;
  localparam int FUNC_W = 6;
  localparam int NFUNC = 43;
  localparam int DATA_W = 32;
  localparam int CODE_W = 7;
  localparam int PIDX_W = 5;
  localparam int RADDR_W = 5;
  localparam int DNUM_W = 6;

  // Input function codes
  localparam logic [FUNC_W-1:0] F_NONE = 6'h00;
  localparam logic [FUNC_W-1:0] F_RUN_POS = 6'h01;
  localparam logic [FUNC_W-1:0] F_RUN_NEG = 6'h02;
  localparam logic [FUNC_W-1:0] F_HOME = 6'h03;
  localparam logic [FUNC_W-1:0] F_START = 6'h04;
  localparam logic [FUNC_W-1:0] F_SEQ = 6'h05;
  localparam logic [FUNC_W-1:0] F_INCH_POS = 6'h06;
  localparam logic [FUNC_W-1:0] F_INCH_NEG = 6'h07;
  localparam logic [FUNC_W-1:0] F_DSEL0 = 6'h08;
  localparam logic [FUNC_W-1:0] F_RELEASE = 6'h0e;
  localparam logic [FUNC_W-1:0] F_EXCITE = 6'h0f;
  localparam logic [FUNC_W-1:0] F_STOP = 6'h10;
  localparam logic [FUNC_W-1:0] F_ALM_CLR = 6'h11;
  localparam logic [FUNC_W-1:0] F_POS_LOAD = 6'h12;
  localparam logic [FUNC_W-1:0] F_ABS_CLR = 6'h13;
  localparam logic [FUNC_W-1:0] F_TOOL = 6'h14;
  localparam logic [FUNC_W-1:0] F_GFLAG0 = 6'h15;
  localparam logic [FUNC_W-1:0] F_DNUM0 = 6'h25;

  // Default input assignment, bit 15 first
  localparam logic [WORD_W-1:0][FUNC_W-1:0] ASSIGN_RST = {
    F_RUN_NEG, F_RUN_POS, F_INCH_NEG, F_INCH_POS, F_SEQ, 6'h0a, 6'h09, F_DSEL0,
    F_NONE, F_RELEASE, F_STOP, F_HOME, F_START, 6'h27, 6'h26, F_DNUM0};

  // Register offsets
  localparam logic [RADDR_W-1:0] REG_ASSIGN0 = 5'h00;
  localparam logic [RADDR_W-1:0] REG_CONFIG = 5'h10;
  localparam logic [RADDR_W-1:0] REG_DIRASG0 = 5'h11;
  localparam logic [RADDR_W-1:0] REG_DSEL_NUM0 = 5'h14;
  localparam logic [RADDR_W-1:0] REG_GFLAGS = 5'h1a;
  localparam logic [RADDR_W-1:0] REG_CMD_STAT = 5'h1b;
  localparam int DIRASG_REGS = 3;
  localparam int DSEL_REGS = 6;

  // Reset values
  localparam logic CONFIG_MODE8_RST = 1'b0;
  localparam logic [47:0] DIRASG_RST = 48'h0;
  localparam logic [DNUM_W-1:0] DSEL_NUM_RST = 6'h00;

  // Command classes in code bits 6:5, index in bits 4:0
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_MONITOR = 2'h2;
  localparam logic [1:0] CMD_MAINT = 2'h3;
  localparam logic [PIDX_W-1:0] MON_FLAGS = 5'h00;
  localparam logic [PIDX_W-1:0] MON_OUTPUT = 5'h01;
  localparam logic [PIDX_W-1:0] MAINT_ALM_CLR = 5'h00;

  // Remote output bit positions
  localparam int OUT_HOME_POS = 4;
  localparam int OUT_READY = 5;
  localparam int OUT_WARNING = 6;
  localparam int OUT_ALARM = 7;
endpackage : remote_io_pkg

//--- core/pmem_if.sv
// Port bundle between the command engine and the parameter store
interface pmem_if #(parameter int AW = 5, parameter int DW = 32);
  logic we;
  logic re;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport master (output we, output re, output addr, output wdata, input rdata);
  modport store (input we, input re, input addr, input wdata, output rdata);
endinterface : pmem_if

//--- core/bit_sync.sv
// Two-flop synchroniser for a bundle of level inputs
module bit_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= async_i;
      stage2_q <= stage1_q;
    end
  end

  assign sync_o = stage2_q;
endmodule : bit_sync

//--- core/param_store.sv
// Parameter word memory with registered read data
module param_store #(
  parameter int AW = 5,
  parameter int DW = 32
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Access port
  pmem_if.store mem
);
  logic [DW-1:0] words [2**AW];
  logic [DW-1:0] rdata_q;

  // No reset on the array so it can map to RAM
  always_ff @(posedge clk_sys_i) begin
    if (mem.we) begin
      words[mem.addr] <= mem.wdata;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (mem.re) begin
      rdata_q <= words[mem.addr];
    end
  end

  assign mem.rdata = rdata_q;
endmodule : param_store

//--- core/remote_io_command_port.sv
// Remote I/O decoder and remote register command engine
module remote_io_command_port (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register port
  input wire logic [remote_io_pkg::RADDR_W-1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Remote I/O words
  input wire logic [remote_io_pkg::WORD_W-1:0] remote_input_bit_i,
  output logic [remote_io_pkg::WORD_W-1:0] remote_output_bit_o,
  // Remote register command and response
  input wire logic [remote_io_pkg::CODE_W-1:0] cmd_code_i,
  input wire logic command_strobe_i,
  input wire logic [remote_io_pkg::DATA_W-1:0] cmd_data_i,
  output logic [remote_io_pkg::CODE_W-1:0] resp_code_o,
  output logic completion_ack_o,
  output logic resp_status_o,
  output logic [remote_io_pkg::DATA_W-1:0] resp_data_o,
  // Direct terminal functions
  input wire logic [remote_io_pkg::NFUNC-1:0] direct_func_i,
  // Drive state
  input wire logic alarm_flag_i,
  input wire logic warning_flag_i,
  input wire logic ready_i,
  input wire logic moving_i,
  input wire logic home_pos_i,
  input wire logic pos_end_i,
  input wire logic [2:0] area_i,
  input wire logic torque_limit_flag_i,
  input wire logic shaft_timing_pulse_i,
  input wire logic internal_busy_flag_i,
  // Motion and control requests
  output logic run_positive_o,
  output logic run_negative_o,
  output logic home_go_o,
  output logic start_go_o,
  output logic sequence_go_o,
  output logic inch_positive_o,
  output logic inch_negative_o,
  output logic direct_go_o,
  output logic [remote_io_pkg::DNUM_W-1:0] data_number_o,
  output logic release_o,
  output logic excite_o,
  output logic stop_o,
  output logic alarm_clear_o,
  output logic abs_error_clear_o,
  output logic position_load_o,
  output logic tool_unlock_o,
  output logic [15:0] general_flags_o
);
  import remote_io_pkg::*;

  typedef enum {IDLE, EXEC, FIN, DONE} cmd_state_type;

  localparam int LINK_W = WORD_W + CODE_W + 1 + DATA_W;

  function automatic logic [1:0] func_hit(input logic [WORD_W-1:0][FUNC_W-1:0] tbl,
                                          input logic [WORD_W-1:0] word,
                                          input logic [WORD_W-1:0] en,
                                          input logic [FUNC_W-1:0] f);
    logic asg;
    logic act;
    asg = 1'b0;
    act = 1'b0;
    for (int i = 0; i < WORD_W; i++) begin
      if (en[i] && tbl[i] == f) begin
        asg = 1'b1;
        act = act | word[i];
      end
    end
    return {asg, act};
  endfunction : func_hit

  function automatic logic [DNUM_W-1:0] pick_dsel(input logic [5:0] rise,
                                                  input logic [5:0][DNUM_W-1:0] nums);
    logic [DNUM_W-1:0] n;
    n = '0;
    for (int k = 5; k >= 0; k--) begin
      if (rise[k]) begin
        n = nums[k];
      end
    end
    return n;
  endfunction : pick_dsel

  // Synchronised link and terminal inputs
  logic [LINK_W-1:0] link_s;
  logic [NFUNC-1:0] dir_s;
  logic [WORD_W-1:0] net_word;
  logic [CODE_W-1:0] code_s;
  logic strobe_s;
  logic [DATA_W-1:0] data_s;

  bit_sync #(.W(LINK_W)) u_link_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i({remote_input_bit_i, cmd_code_i, command_strobe_i, cmd_data_i}),
    .sync_o(link_s)
  );

  bit_sync #(.W(NFUNC)) u_dir_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(direct_func_i),
    .sync_o(dir_s)
  );

  assign net_word = link_s[LINK_W-1 -: WORD_W];
  assign code_s = link_s[DATA_W+1 +: CODE_W];
  assign strobe_s = link_s[DATA_W];
  // byte order: byte k of the transfer sits in lane k, lane 0 least significant
  assign data_s = link_s[DATA_W-1:0];

  // Configuration registers
  logic [WORD_W-1:0][FUNC_W-1:0] assign_q;
  logic mode8_q;
  logic [47:0] dir_asg_q;
  logic [DSEL_REGS-1:0][DNUM_W-1:0] dsel_num_q;
  logic [15:0] reg_rdata_q;
  logic [15:0] rd_mux;
  logic [RADDR_W-1:0] dir_off;
  logic [RADDR_W-1:0] dsel_off;
  logic wr_assign;
  logic wr_config;
  logic wr_dir;
  logic wr_dsel;

  assign dir_off = reg_addr_i - REG_DIRASG0;
  assign dsel_off = reg_addr_i - REG_DSEL_NUM0;
  assign wr_assign = reg_wr_i && reg_addr_i < REG_CONFIG;
  assign wr_config = reg_wr_i && reg_addr_i == REG_CONFIG;
  assign wr_dir = reg_wr_i && reg_addr_i >= REG_DIRASG0 && dir_off < RADDR_W'(DIRASG_REGS);
  assign wr_dsel = reg_wr_i && reg_addr_i >= REG_DSEL_NUM0 && dsel_off < RADDR_W'(DSEL_REGS);

  // assignment table held per input bit
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      assign_q <= ASSIGN_RST;
      mode8_q <= CONFIG_MODE8_RST;
      dir_asg_q <= DIRASG_RST;
      dsel_num_q <= {DSEL_REGS{DSEL_NUM_RST}};
    end else begin
      if (wr_assign) assign_q[reg_addr_i[3:0]] <= reg_wdata_i[FUNC_W-1:0];
      if (wr_config) mode8_q <= reg_wdata_i[0];
      if (wr_dir) dir_asg_q[16*dir_off[1:0] +: 16] <= reg_wdata_i;
      if (wr_dsel) dsel_num_q[dsel_off[2:0]] <= reg_wdata_i[DNUM_W-1:0];
    end
  end

  // Function decode and merge
  logic [WORD_W-1:0] bit_en;
  logic [NFUNC-1:0] net_asg;
  logic [NFUNC-1:0] net_act;
  logic [NFUNC-1:0] eff;
  logic [NFUNC-1:0] eff_q;
  logic [NFUNC-1:0] rise;

  // narrow mode sees only the low byte
  assign bit_en = mode8_q ? 16'h00ff : 16'hffff;

  for (genvar f = 0; f < NFUNC; f++) begin : g_func
    logic [1:0] hit;
    assign hit = func_hit(assign_q, net_word, bit_en, FUNC_W'(f));
    assign net_asg[f] = hit[1];
    assign net_act[f] = hit[0];
    // both sources must agree; unassigned excite and unlock read 1
    assign eff[f] = (net_asg[f] && dir_asg_q[f]) ? (net_act[f] && dir_s[f]) :
                    net_asg[f] ? net_act[f] :
                    dir_asg_q[f] ? dir_s[f] :
                    (FUNC_W'(f) == F_EXCITE || FUNC_W'(f) == F_TOOL);
  end

  assign rise = eff & ~eff_q;

  // Command engine state
  cmd_state_type st_q;
  logic strobe_q;
  logic strobe_rise;
  logic [CODE_W-1:0] code_q;
  logic [DATA_W-1:0] data_q;
  logic [CODE_W-1:0] resp_code_q;
  logic ack_q;
  logic resp_status_q;
  logic [DATA_W-1:0] resp_data_q;
  logic maint_clr_q;
  logic [1:0] cmd_class;
  logic [PIDX_W-1:0] cmd_idx;
  logic cmd_err;
  logic [DATA_W-1:0] result;
  pmem_if #(.AW(PIDX_W), .DW(DATA_W)) pm ();

  param_store #(.AW(PIDX_W), .DW(DATA_W)) u_store (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .mem(pm.store)
  );

  // only a fresh rising strobe starts a command
  assign strobe_rise = strobe_s && !strobe_q;
  // class and index from the code
  assign cmd_class = code_q[CODE_W-1 -: 2];
  assign cmd_idx = code_q[PIDX_W-1:0];
  assign pm.we = st_q == EXEC && cmd_class == CMD_WRITE;
  assign pm.re = st_q == EXEC && cmd_class == CMD_READ;
  assign pm.addr = cmd_idx;
  assign pm.wdata = data_q;
  assign cmd_err = (cmd_class == CMD_MONITOR && cmd_idx > MON_OUTPUT) ||
                   (cmd_class == CMD_MAINT && cmd_idx != MAINT_ALM_CLR);
  // results keep the least significant byte in lane 0
  assign result = cmd_class == CMD_READ ? pm.rdata :
                  cmd_class == CMD_MONITOR && cmd_idx == MON_FLAGS ? {16'h0000, general_flags_o} :
                  cmd_class == CMD_MONITOR && cmd_idx == MON_OUTPUT ? {16'h0000, remote_output_bit_o} :
                  '0;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= IDLE;
      strobe_q <= 1'b0;
      code_q <= '0;
      data_q <= '0;
      resp_code_q <= '0;
      ack_q <= 1'b0;
      resp_status_q <= 1'b0;
      resp_data_q <= '0;
      maint_clr_q <= 1'b0;
    end else begin
      strobe_q <= strobe_s;
      maint_clr_q <= st_q == FIN && cmd_class == CMD_MAINT && !cmd_err;
      case (st_q)
        IDLE: begin
          if (strobe_rise) begin
            code_q <= code_s;
            data_q <= data_s;
            st_q <= EXEC;
          end
        end
        EXEC: st_q <= FIN;
        FIN: begin
          resp_code_q <= code_q;
          resp_status_q <= cmd_err;
          resp_data_q <= result;
          ack_q <= 1'b1;
          st_q <= DONE;
        end
        DONE: begin
          // held until the master drops the strobe
          if (!strobe_s) begin
            ack_q <= 1'b0;
            st_q <= IDLE;
          end
        end
        default: st_q <= IDLE;
      endcase
    end
  end

  // Request outputs
  logic [WORD_W-1:0] out_word;
  logic [WORD_W-1:0] out_q;
  logic [15:0] gflags_q;
  logic [9:0] lvl_q;
  logic [5:0] go_q;
  logic [DNUM_W-1:0] dnum_q;
  logic [5:0] dsel_rise;
  logic start_type_rise;

  assign dsel_rise = rise[F_DSEL0 +: 6];
  assign start_type_rise = rise[F_START] || rise[F_SEQ] || |dsel_rise;

  // drive state bits; echoes; low byte defaults
  assign out_word = {torque_limit_flag_i, pos_end_i, moving_i, shaft_timing_pulse_i, area_i,
                     internal_busy_flag_i, alarm_flag_i, warning_flag_i, ready_i, home_pos_i,
                     eff[F_START], eff[F_DNUM0 +: 3]};

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      eff_q <= '0;
      out_q <= '0;
      gflags_q <= '0;
      lvl_q <= '0;
      go_q <= '0;
      dnum_q <= '0;
    end else begin
      eff_q <= eff;
      // upper byte idle in narrow mode
      out_q <= mode8_q ? {8'h00, out_word[7:0]} : out_word;
      gflags_q <= eff[F_GFLAG0 +: 16];
      // run levels; release and excite; stop; clears; unlock
      lvl_q <= {eff[F_RUN_POS], eff[F_RUN_NEG], eff[F_RELEASE], eff[F_EXCITE], eff[F_STOP],
                eff[F_ALM_CLR] | maint_clr_q, eff[F_ABS_CLR], eff[F_POS_LOAD], eff[F_TOOL], 1'b0};
      // start-type operations fire on the 0-to-1 change
      go_q <= {rise[F_HOME], rise[F_START], rise[F_SEQ], rise[F_INCH_POS], rise[F_INCH_NEG], |dsel_rise};
      if (start_type_rise) begin
        // direct select uses its own number; otherwise the select bits
        dnum_q <= |dsel_rise ? pick_dsel(dsel_rise, dsel_num_q) : eff[F_DNUM0 +: DNUM_W];
      end
    end
  end

  // Register read answer, valid in the cycle after the strobe only
  assign rd_mux = reg_addr_i < REG_CONFIG ? {10'h000, assign_q[reg_addr_i[3:0]]} :
                  reg_addr_i == REG_CONFIG ? {15'h0000, mode8_q} :
                  wr_dir | (reg_addr_i >= REG_DIRASG0 && dir_off < RADDR_W'(DIRASG_REGS)) ?
                    dir_asg_q[16*dir_off[1:0] +: 16] :
                  reg_addr_i >= REG_DSEL_NUM0 && dsel_off < RADDR_W'(DSEL_REGS) ?
                    {10'h000, dsel_num_q[dsel_off[2:0]]} :
                  reg_addr_i == REG_GFLAGS ? gflags_q :
                  reg_addr_i == REG_CMD_STAT ? {6'h00, resp_status_q, ack_q, 1'b0, resp_code_q} :
                  16'h0000;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_q <= 16'h0000;
    end else begin
      reg_rdata_q <= reg_rd_i ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata_o = reg_rdata_q;
  assign remote_output_bit_o = out_q;
  assign resp_code_o = resp_code_q;
  assign completion_ack_o = ack_q;
  assign resp_status_o = resp_status_q;
  assign resp_data_o = resp_data_q;
  assign general_flags_o = gflags_q;
  assign {run_positive_o, run_negative_o, release_o, excite_o, stop_o} = lvl_q[9:5];
  assign {alarm_clear_o, abs_error_clear_o, position_load_o, tool_unlock_o} = lvl_q[4:1];
  assign {home_go_o, start_go_o, sequence_go_o, inch_positive_o, inch_negative_o, direct_go_o} = go_q;
  assign data_number_o = dnum_q;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_cmd_taken;
    st_q == IDLE && strobe_rise;
  endsequence
  sequence s_cmd_answered;
    !completion_ack_o ##2 completion_ack_o;
  endsequence

  a_ack_after_strobe: assert property (s_cmd_taken |=> s_cmd_answered)
    else $error("acknowledge not three cycles after strobe rise");
  a_idle_without_strobe: assert property ((st_q == IDLE && !strobe_rise) |=> st_q == IDLE)
    else $error("command started without strobe rise");
  a_resp_code_echo: assert property (s_cmd_taken |-> ##3 resp_code_o == $past(code_s, 3))
    else $error("response code differs from command code");
  a_ack_release: assert property ((completion_ack_o && !strobe_s) |=> !completion_ack_o)
    else $error("acknowledge held after strobe low");
  a_monitor_error: assert property (s_cmd_taken ##1 (cmd_class == CMD_MONITOR && cmd_idx > MON_OUTPUT)
                                    |-> ##2 resp_status_o)
    else $error("bad monitor index not flagged");
  a_monitor_data: assert property (s_cmd_taken ##1 (cmd_class == CMD_MONITOR && cmd_idx == MON_FLAGS)
                                   |-> ##2 resp_data_o == {16'h0000, $past(gflags_q)})
    else $error("monitor data wrong");
  a_run_follows_bit: assert property ((!mode8_q && assign_q[14] == F_RUN_POS && !dir_asg_q[F_RUN_POS]
                                       && net_word[14]) |=> run_positive_o)
    else $error("run request missing");
  a_start_one_cycle: assert property (start_go_o |=> !start_go_o)
    else $error("start pulse longer than one cycle");
  a_excite_default: assert property ((!net_asg[F_EXCITE] && !dir_asg_q[F_EXCITE]) |=> excite_o)
    else $error("unassigned excitation not on");
  a_both_sources: assert property ((net_asg[F_STOP] && dir_asg_q[F_STOP] && !dir_s[F_STOP]) |=> !stop_o)
    else $error("stop acted on one source only");
  a_narrow_upper: assert property (mode8_q |=> remote_output_bit_o[15:8] == 8'h00)
    else $error("upper output byte active in narrow mode");
  a_alarm_out: assert property (alarm_flag_i |=> remote_output_bit_o[OUT_ALARM])
    else $error("alarm output bit not set");
endmodule : remote_io_command_port

//--- dv/net_master_model.sv
// Network master model driving the remote register command link
module net_master_model (
  // Clock
  input wire logic clk_sys_i,
  // Requests from the bench
  input wire logic go_i,
  input wire logic [6:0] code_i,
  input wire logic [31:0] data_i,
  input wire logic [3:0] slow_i,
  // Command link
  input wire logic completion_ack_i,
  output logic [6:0] cmd_code_o,
  output logic command_strobe_o,
  output logic [31:0] cmd_data_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {cmd_code_o, command_strobe_o, cmd_data_o, busy_o} = '0;
    forever begin
      @(posedge clk_sys_i);
      if (go_i) begin
        busy_o <= 1'b1;
        cmd_code_o <= code_i;
        cmd_data_o <= data_i;
        command_strobe_o <= 1'b1;
        repeat (40) if (!completion_ack_i) @(posedge clk_sys_i);
        repeat (slow_i) @(posedge clk_sys_i);
        command_strobe_o <= 1'b0;
        // Released data no longer hold the last value
        cmd_data_o <= ~cmd_data_o;
        repeat (40) if (completion_ack_i) @(posedge clk_sys_i);
        busy_o <= 1'b0;
      end
    end
  end
endmodule : net_master_model

//--- dv/tb_top.sv
// Self-checking bench for the remote I/O command port
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb_top import remote_io_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [6:0] c; logic s; logic [31:0] d; logic k;} resp_type;
  logic clk_sys_i, rst_i, reg_wr_i, reg_rd_i, command_strobe_i, completion_ack_o, resp_status_o;
  logic [4:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, remote_input_bit_i, remote_output_bit_o, general_flags_o;
  logic [6:0] cmd_code_i, resp_code_o, mcode;
  logic [31:0] cmd_data_i, resp_data_o, mdata, d;
  logic [42:0] direct_func_i;
  logic alarm_flag_i, warning_flag_i, ready_i, moving_i, home_pos_i, pos_end_i, torque_limit_flag_i;
  logic shaft_timing_pulse_i, internal_busy_flag_i, run_positive_o, run_negative_o, home_go_o, start_go_o;
  logic sequence_go_o, inch_positive_o, inch_negative_o, direct_go_o, release_o, excite_o, stop_o;
  logic alarm_clear_o, abs_error_clear_o, position_load_o, tool_unlock_o, go, mbusy;
  logic rd_d = 1'b0, ack_d = 1'b0;
  logic [2:0] area_i;
  logic [5:0] data_number_o;
  logic [3:0] slow, lv;
  logic [11:0] dv;
  int num_errors, samples_checked, n_clr, n_start, n_dir, n_go, seed, i;
  int pos[4] = '{5, 6, 14, 15};
  logic [15:0] rq[$];
  logic [15:0] r;
  resp_type cq[$];
  resp_type e;
  assign {torque_limit_flag_i, pos_end_i, moving_i, shaft_timing_pulse_i, area_i, internal_busy_flag_i,
    alarm_flag_i, warning_flag_i, ready_i, home_pos_i} = dv;
  assign lv = {run_negative_o, run_positive_o, release_o, stop_o};
  remote_io_command_port dut_u (.*);
  net_master_model master_u (.clk_sys_i(clk_sys_i), .go_i(go), .code_i(mcode), .data_i(mdata),
    .slow_i(slow), .completion_ack_i(completion_ack_o), .cmd_code_o(cmd_code_i),
    .command_strobe_o(command_strobe_i), .cmd_data_o(cmd_data_i), .busy_o(mbusy));
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // Oldest expectation is taken when a result appears
  always @(posedge clk_sys_i) begin
    if (rd_d) begin
      r = rq.pop_front();
      `CHK("reg read", r, reg_rdata_o)
    end
    if (completion_ack_o && !ack_d) begin
      e = cq.pop_front();
      `CHK("resp code", e.c, resp_code_o)
      `CHK("status", e.s, resp_status_o)
      if (e.k) `CHK("resp data", e.d, resp_data_o)
    end
    rd_d <= reg_rd_i;
    ack_d <= completion_ack_o;
    if (alarm_clear_o) n_clr++;
    if (start_go_o) n_start++;
    if (direct_go_o) n_dir++;
    n_go += home_go_o + sequence_go_o + inch_positive_o + inch_negative_o;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i) reg_wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] v);
    rq.push_back(v);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i) reg_rd_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : rd
  task automatic cmd(input logic [6:0] c, input logic [31:0] v, input logic s, input logic [31:0] x,
    input logic k);
    cq.push_back('{c, s, x, k});
    mcode <= c;
    mdata <= v;
    go <= 1'b1;
    @(posedge clk_sys_i) go <= 1'b0;
    repeat (80) begin
      @(posedge clk_sys_i);
      if (!mbusy) break;
    end
    if (mbusy) num_errors++;
  endtask : cmd
  task automatic net(input logic [15:0] w);
    remote_input_bit_i <= w;
    repeat (6) @(posedge clk_sys_i);
  endtask : net
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    complete_run();
  end
  initial begin
    seed = 32'h52f0;
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, remote_input_bit_i, direct_func_i} = '0;
    {go, mcode, mdata, dv, slow} = '0;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    `CHK("excite", 1'b1, excite_o)
    `CHK("unlock", 1'b1, tool_unlock_o)
    for (i = 0; i < 16; i++) rd(i[4:0], {10'h0, ASSIGN_RST[i]});
    rd(REG_CONFIG, 16'h0);
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      slow <= 4'(i * 5);
      cmd({CMD_WRITE, i[4:0]}, d, 1'b0, 32'h0, 1'b0);
      cmd({CMD_READ, i[4:0]}, ~d, 1'b0, d, 1'b1);
    end
    cmd({CMD_MONITOR, 5'h07}, d, 1'b1, 32'h0, 1'b0);
    cmd({CMD_MAINT, 5'h01}, d, 1'b1, 32'h0, 1'b0);
    cmd({CMD_MAINT, MAINT_ALM_CLR}, d, 1'b0, 32'h0, 1'b0);
    `CHK("ack idle", 1'b0, completion_ack_o)
    `CHK("clear pulses", 1, n_clr)
    for (i = 0; i < 4; i++) begin
      net(16'h1 << pos[i]);
      `CHK("level", 4'h1 << i, lv)
      net(16'h0);
      `CHK("level off", 4'h0, lv)
    end
    net(16'h3810);
    `CHK("go pulses", 4, n_go)
    dv <= 12'($random(seed));
    net(16'h0005);
    net(16'h000d);
    `CHK("data number", 6'h05, data_number_o)
    `CHK("out word", {dv, 4'hd}, remote_output_bit_o)
    `CHK("start pulses", 1, n_start)
    wr(REG_DSEL_NUM0 + 5'h01, 16'h002a);
    net(16'h0200);
    `CHK("direct number", 6'h2a, data_number_o)
    `CHK("direct pulses", 1, n_dir)
    wr(5'h07, 16'(F_RUN_POS));
    net(16'h0080);
    `CHK("shared bit", 1'b1, run_positive_o)
    wr(REG_DIRASG0, 16'h0002);
    wr(REG_DIRASG0 + 5'h01, 16'h000d);
    repeat (4) @(posedge clk_sys_i);
    `CHK("terminal low", 1'b0, run_positive_o)
    direct_func_i <= 43'h0c0002;
    repeat (6) @(posedge clk_sys_i);
    `CHK("both high", 1'b1, run_positive_o)
    `CHK("terminal clears", 2'h3, {abs_error_clear_o, position_load_o})
    wr(5'h07, 16'(F_GFLAG0 + 6'h03));
    repeat (6) @(posedge clk_sys_i);
    `CHK("flags", 16'h0008, general_flags_o)
    rd(REG_GFLAGS, 16'h0008);
    cmd({CMD_MONITOR, MON_FLAGS}, d, 1'b0, 32'h8, 1'b1);
    for (i = 0; i < 2; i++) begin
      wr(5'h07, 16'(i ? F_TOOL : F_EXCITE));
      net(16'h0);
      `CHK("assigned off", 1'b0, i ? tool_unlock_o : excite_o)
      net(16'h0080);
      `CHK("assigned on", 1'b1, i ? tool_unlock_o : excite_o)
    end
    wr(REG_CONFIG, 16'h0001);
    net(16'h80a0);
    `CHK("narrow out", {8'h0, dv[3:0], 4'h0}, remote_output_bit_o)
    `CHK("narrow in", 2'h0, {run_negative_o, stop_o})
    rd(REG_CMD_STAT, 16'h0040);
    cmd({CMD_MONITOR, MON_OUTPUT}, d, 1'b0, {24'h0, dv[3:0], 4'h0}, 1'b1);
    `CHK("pending", 0, cq.size() + rq.size())
    complete_run();
  end
endmodule : tb_top
